// file: verilog/dic_pkg.sv
// constants shared by the digital input conditioner
package dic_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NCH    = 8;
    localparam int VOLT_W = 19;
    localparam int THR_W  = 11;
    localparam int DLY_W  = 21;
    localparam int CNT_W  = 32;
    localparam int ACC_W  = 22;
    localparam int OUT_N  = 5;
    localparam int ADDR_W = 12;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ         = 100_000_000;
    localparam int SCAN_PERIOD_MS = 5;
    localparam int SCAN_CYCLES    = CLK_HZ / 1000 * SCAN_PERIOD_MS;
    localparam int AC_DROP_MS     = 30;
    // ------------------------------------------------------------
    // scaling: thresholds in 0.1 V steps, voltage in mV
    // ------------------------------------------------------------
    localparam int MV_PER_THR_STEP = 100;
    localparam int AC_REL_PCT      = 10;
    // ------------------------------------------------------------
    // byte offsets: per channel block, then globals
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CH_STRIDE    = 12'h020;
    localparam logic [ADDR_W-1:0] OFF_CFG      = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_ACT_THR  = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_REL_THR  = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_ACT_DLY  = 12'h00C;
    localparam logic [ADDR_W-1:0] OFF_DROP_DLY = 12'h010;
    localparam logic [ADDR_W-1:0] OFF_COUNT    = 12'h014;
    localparam logic [ADDR_W-1:0] OFF_VOLT     = 12'h018;
    localparam logic [ADDR_W-1:0] OFF_CNT_CLR  = 12'h01C;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 12'h100;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 12'h104;
    localparam logic [ADDR_W-1:0] OFF_IRQ_CLR  = 12'h108;
    localparam logic [ADDR_W-1:0] OFF_IRQ_EN   = 12'h10C;
    localparam logic [ADDR_W-1:0] OFF_OUT_CTRL = 12'h110;
    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int CFG_NC_BIT  = 0;
    localparam int CFG_AC_BIT  = 1;
    localparam int CLR_BIT     = 0;
    localparam logic [THR_W-1:0] ACT_THR_RST = 11'h370;
    localparam logic [THR_W-1:0] REL_THR_RST = 11'h258;
    localparam logic [THR_W-1:0] ACT_THR_MIN = 11'h0A0;
    localparam logic [THR_W-1:0] REL_THR_MIN = 11'h064;
    localparam logic [THR_W-1:0] THR_MAX     = 11'h7D0;
    localparam logic [DLY_W-1:0] DLY_RST     = 21'h000000;
    localparam logic [DLY_W-1:0] DLY_MAX     = 21'h1B7740;
    // ------------------------------------------------------------
    // register decode codes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        RC_CFG      = 4'h0,
        RC_ACT_THR  = 4'h1,
        RC_REL_THR  = 4'h2,
        RC_ACT_DLY  = 4'h3,
        RC_DROP_DLY = 4'h4,
        RC_COUNT    = 4'h5,
        RC_VOLT     = 4'h6,
        RC_CNT_CLR  = 4'h7,
        RC_STATUS   = 4'h8,
        RC_IRQ_STAT = 4'h9,
        RC_IRQ_CLR  = 4'hA,
        RC_IRQ_EN   = 4'hB,
        RC_OUT_CTRL = 4'hC,
        RC_NONE     = 4'hF
    } dic_reg_t;
endpackage

// file: verilog/dic_input_conditioner.sv
// eight channel digital input conditioner with apb registers
// Function
// - per channel polarity, normally open by default, flips reported status
// - activation threshold 16.0..200.0 V in 0.1 V steps, default 88 V
// - voltage above activation threshold energizes the input
// - release threshold 10.0..200.0 V in 0.1 V steps, default 60 V
// - voltage below release threshold de-energizes the input unless it is above the activation threshold
// - 0 to 1 status change delayed by activation delay in ms
// - 1 to 0 status change delayed by drop-off delay in ms
// - ac mode adds fixed 30 ms to the drop-off delay
// - ac mode release threshold is 10 percent of activation threshold
// - 32-bit counter counts 0 to 1 status transitions
// - clear command zeroes the channel counter, or sets it to 1 if a 0 to 1 transition counts in that cycle; stores nothing
// - present channel voltage readable in mV, 0..275 V
// - five outputs refreshed from control register every 5 ms
// - all channels sampled and updated on the 5 ms scan tick
// - eight channels, each fully independent
`timescale 1ns/100ps
`default_nettype none
module dic_input_conditioner #(
    parameter int SCAN_CYCLES = dic_pkg::SCAN_CYCLES
) (
    input  wire logic                                         i_clk,
    input  wire logic                                         i_rst,
    input  wire logic [dic_pkg::NCH*dic_pkg::VOLT_W-1:0]      i_volt_mv,
    input  wire logic                                         i_psel,
    input  wire logic                                         i_penable,
    input  wire logic                                         i_pwrite,
    input  wire logic [dic_pkg::ADDR_W-1:0]                   i_paddr,
    input  wire logic [31:0]                                  i_pwdata,
    output logic      [31:0]                                  o_prdata,
    output logic                                              o_pready,
    output logic                                              o_pslverr,
    output logic      [dic_pkg::NCH-1:0]                      o_status,
    output logic      [dic_pkg::OUT_N-1:0]                    o_out,
    output logic                                              o_irq
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic dic_pkg::dic_reg_t reg_code(input logic [dic_pkg::ADDR_W-1:0] a);
        logic [dic_pkg::ADDR_W-1:0] lo;
        lo = a & (dic_pkg::CH_STRIDE - 12'h001);
        reg_code = dic_pkg::RC_NONE;
        if (a < dic_pkg::CH_STRIDE * 12'h008) begin
            case (lo)
                dic_pkg::OFF_CFG:      reg_code = dic_pkg::RC_CFG;
                dic_pkg::OFF_ACT_THR:  reg_code = dic_pkg::RC_ACT_THR;
                dic_pkg::OFF_REL_THR:  reg_code = dic_pkg::RC_REL_THR;
                dic_pkg::OFF_ACT_DLY:  reg_code = dic_pkg::RC_ACT_DLY;
                dic_pkg::OFF_DROP_DLY: reg_code = dic_pkg::RC_DROP_DLY;
                dic_pkg::OFF_COUNT:    reg_code = dic_pkg::RC_COUNT;
                dic_pkg::OFF_VOLT:     reg_code = dic_pkg::RC_VOLT;
                dic_pkg::OFF_CNT_CLR:  reg_code = dic_pkg::RC_CNT_CLR;
                default:               reg_code = dic_pkg::RC_NONE;
            endcase
        end else begin
            case (a)
                dic_pkg::OFF_STATUS:   reg_code = dic_pkg::RC_STATUS;
                dic_pkg::OFF_IRQ_STAT: reg_code = dic_pkg::RC_IRQ_STAT;
                dic_pkg::OFF_IRQ_CLR:  reg_code = dic_pkg::RC_IRQ_CLR;
                dic_pkg::OFF_IRQ_EN:   reg_code = dic_pkg::RC_IRQ_EN;
                dic_pkg::OFF_OUT_CTRL: reg_code = dic_pkg::RC_OUT_CTRL;
                default:               reg_code = dic_pkg::RC_NONE;
            endcase
        end
    endfunction

    function automatic logic [dic_pkg::THR_W-1:0] clamp_thr(input logic [31:0] v,
                                                            input logic [dic_pkg::THR_W-1:0] lo);
        if (v < 32'(lo))
            clamp_thr = lo;
        else if (v > 32'(dic_pkg::THR_MAX))
            clamp_thr = dic_pkg::THR_MAX;
        else
            clamp_thr = v[dic_pkg::THR_W-1:0];
    endfunction

    function automatic logic [dic_pkg::DLY_W-1:0] clamp_dly(input logic [31:0] v);
        clamp_dly = (v > 32'(dic_pkg::DLY_MAX)) ? dic_pkg::DLY_MAX : v[dic_pkg::DLY_W-1:0];
    endfunction

    function automatic logic [dic_pkg::VOLT_W-1:0] thr_mv(input logic [dic_pkg::THR_W-1:0] t);
        thr_mv = dic_pkg::VOLT_W'(32'(t) * dic_pkg::MV_PER_THR_STEP);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    localparam int NCH = dic_pkg::NCH;
    logic [dic_pkg::VOLT_W-1:0] volt_s1_r   [NCH];
    logic [dic_pkg::VOLT_W-1:0] volt_s2_r   [NCH];
    logic [dic_pkg::VOLT_W-1:0] volt_s3_r   [NCH];
    logic [dic_pkg::VOLT_W-1:0] volt_r      [NCH];
    logic [NCH-1:0]             nc_r;
    logic [NCH-1:0]             ac_r;
    logic [dic_pkg::THR_W-1:0]  act_thr_r   [NCH];
    logic [dic_pkg::THR_W-1:0]  rel_thr_r   [NCH];
    logic [dic_pkg::DLY_W-1:0]  act_dly_r   [NCH];
    logic [dic_pkg::DLY_W-1:0]  drop_dly_r  [NCH];
    logic [dic_pkg::CNT_W-1:0]  count_r     [NCH];
    logic [dic_pkg::ACC_W-1:0]  acc_r       [NCH];
    logic [dic_pkg::VOLT_W-1:0] rel_mv      [NCH];
    logic [dic_pkg::ACC_W-1:0]  target      [NCH];
    logic [NCH-1:0]             energ_r;
    logic [NCH-1:0]             energ_nxt;
    logic [NCH-1:0]             raw_nxt;
    logic [NCH-1:0]             status_r;
    logic [NCH-1:0]             clr_cmd;
    logic [NCH-1:0]             irq_stat_r;
    logic [NCH-1:0]             irq_en_r;
    logic [dic_pkg::OUT_N-1:0]  out_ctrl_r;
    logic [31:0]                scan_cnt_r;
    logic                       scan_tick;
    logic                       access;
    logic                       wr_en;
    logic [2:0]                 wr_ch;
    dic_pkg::dic_reg_t          wr_code;
    dic_pkg::dic_reg_t          rd_code;
    logic [31:0]                rd_data;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // ------------------------------------------------------------
    // scan tick divider
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst || scan_tick)
            scan_cnt_r <= 32'h00000000;
        else
            scan_cnt_r <= scan_cnt_r + 32'h00000001;
    end
    assign scan_tick = (scan_cnt_r == 32'(SCAN_CYCLES - 1));

    a_tick_period: assert property (scan_tick |=> !scan_tick [*2])
        else $error("scan tick repeated too soon");

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    assign access  = i_psel && i_penable;
    assign wr_en   = access && o_pready && i_pwrite;
    assign wr_code = reg_code(i_paddr);
    assign rd_code = reg_code(i_paddr);
    assign wr_ch   = i_paddr[7:5];

    always_comb begin
        rd_data = 32'h00000000;
        case (rd_code)
            dic_pkg::RC_CFG:      rd_data = 32'({ac_r[wr_ch], nc_r[wr_ch]});
            dic_pkg::RC_ACT_THR:  rd_data = 32'(act_thr_r[wr_ch]);
            dic_pkg::RC_REL_THR:  rd_data = 32'(rel_thr_r[wr_ch]);
            dic_pkg::RC_ACT_DLY:  rd_data = 32'(act_dly_r[wr_ch]);
            dic_pkg::RC_DROP_DLY: rd_data = 32'(drop_dly_r[wr_ch]);
            dic_pkg::RC_COUNT:    rd_data = count_r[wr_ch];
            dic_pkg::RC_VOLT:     rd_data = 32'(volt_r[wr_ch]);
            dic_pkg::RC_STATUS:   rd_data = 32'(status_r);
            dic_pkg::RC_IRQ_STAT: rd_data = 32'(irq_stat_r);
            dic_pkg::RC_IRQ_EN:   rd_data = 32'(irq_en_r);
            dic_pkg::RC_OUT_CTRL: rd_data = 32'(out_ctrl_r);
            default:              rd_data = 32'h00000000;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h00000000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= access && !o_pready;
            o_prdata  <= (access && !o_pready && !i_pwrite) ? rd_data : 32'h00000000;
            o_pslverr <= access && !o_pready && (rd_code == dic_pkg::RC_NONE);
        end
    end

    a_apb_answer: assert property (access && !o_pready |=> o_pready ##1 !o_pready)
        else $error("apb answer not one cycle after access");

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            nc_r       <= '0;
            ac_r       <= '0;
            irq_en_r   <= '0;
            out_ctrl_r <= '0;
            for (int i = 0; i < NCH; i++) begin
                act_thr_r[i]  <= dic_pkg::ACT_THR_RST;
                rel_thr_r[i]  <= dic_pkg::REL_THR_RST;
                act_dly_r[i]  <= dic_pkg::DLY_RST;
                drop_dly_r[i] <= dic_pkg::DLY_RST;
            end
        end else if (wr_en) begin
            case (wr_code)
                dic_pkg::RC_CFG: begin
                    nc_r[wr_ch] <= i_pwdata[dic_pkg::CFG_NC_BIT];
                    ac_r[wr_ch] <= i_pwdata[dic_pkg::CFG_AC_BIT];
                end
                dic_pkg::RC_ACT_THR:  act_thr_r[wr_ch]  <= clamp_thr(i_pwdata, dic_pkg::ACT_THR_MIN);
                dic_pkg::RC_REL_THR:  rel_thr_r[wr_ch]  <= clamp_thr(i_pwdata, dic_pkg::REL_THR_MIN);
                dic_pkg::RC_ACT_DLY:  act_dly_r[wr_ch]  <= clamp_dly(i_pwdata);
                dic_pkg::RC_DROP_DLY: drop_dly_r[wr_ch] <= clamp_dly(i_pwdata);
                dic_pkg::RC_IRQ_EN:   irq_en_r          <= i_pwdata[NCH-1:0];
                dic_pkg::RC_OUT_CTRL: out_ctrl_r        <= i_pwdata[dic_pkg::OUT_N-1:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        clr_cmd = '0;
        if (wr_en && wr_code == dic_pkg::RC_CNT_CLR && i_pwdata[dic_pkg::CLR_BIT])
            clr_cmd[wr_ch] = 1'b1;
    end

    // ------------------------------------------------------------
    // voltage input synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        for (int i = 0; i < NCH; i++) begin
            if (i_rst) begin
                volt_s1_r[i] <= '0;
                volt_s2_r[i] <= '0;
                volt_s3_r[i] <= '0;
                volt_r[i]    <= '0;
            end else begin
                volt_s1_r[i] <= i_volt_mv[i*dic_pkg::VOLT_W +: dic_pkg::VOLT_W];
                volt_s2_r[i] <= volt_s1_r[i];
                volt_s3_r[i] <= volt_s2_r[i];
                // word taken only once it held two clocks, so a torn sample is never used
                if (volt_s2_r[i] == volt_s3_r[i])
                    volt_r[i] <= volt_s2_r[i];
            end
        end
    end

    // ------------------------------------------------------------
    // threshold comparison and delay timing
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            rel_mv[i] = ac_r[i] ? dic_pkg::VOLT_W'(32'(thr_mv(act_thr_r[i])) * dic_pkg::AC_REL_PCT / 100)
                                : thr_mv(rel_thr_r[i]);
            if (volt_r[i] > thr_mv(act_thr_r[i]))
                energ_nxt[i] = 1'b1;
            else if (volt_r[i] < rel_mv[i])
                energ_nxt[i] = 1'b0;
            else
                energ_nxt[i] = energ_r[i];
            raw_nxt[i] = energ_nxt[i] ^ nc_r[i];
            target[i]  = raw_nxt[i] ? dic_pkg::ACC_W'(act_dly_r[i])
                                    : dic_pkg::ACC_W'(drop_dly_r[i])
                                      + (ac_r[i] ? dic_pkg::ACC_W'(dic_pkg::AC_DROP_MS) : '0);
        end
    end

    always_ff @(posedge i_clk) begin
        for (int i = 0; i < NCH; i++) begin
            if (i_rst) begin
                energ_r[i]  <= 1'b0;
                status_r[i] <= 1'b0;
                acc_r[i]    <= '0;
            end else if (scan_tick) begin
                energ_r[i] <= energ_nxt[i];
                if (raw_nxt[i] == status_r[i]) begin
                    acc_r[i] <= '0;
                end else if (acc_r[i] >= target[i]) begin
                    status_r[i] <= raw_nxt[i];
                    acc_r[i]    <= '0;
                end else begin
                    acc_r[i] <= acc_r[i] + dic_pkg::ACC_W'(dic_pkg::SCAN_PERIOD_MS);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // transition counters and interrupt status
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        for (int i = 0; i < NCH; i++) begin
            if (i_rst)
                count_r[i] <= '0;
            else if (scan_tick && !status_r[i] && raw_nxt[i] && acc_r[i] >= target[i])
                count_r[i] <= clr_cmd[i] ? 32'h00000001 : count_r[i] + 32'h00000001;
            else if (clr_cmd[i])
                count_r[i] <= '0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst)
            irq_stat_r <= '0;
        else
            irq_stat_r <= (irq_stat_r & ~((wr_en && wr_code == dic_pkg::RC_IRQ_CLR) ? i_pwdata[NCH-1:0] : '0))
                          | (o_status ^ status_r);
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_status <= '0;
            o_out    <= '0;
            o_irq    <= 1'b0;
        end else begin
            o_status <= status_r;
            o_irq    <= |(irq_stat_r & irq_en_r);
            if (scan_tick)
                o_out <= out_ctrl_r;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_tick_then_status(int k);
        scan_tick ##1 $changed(status_r[k]);
    endsequence

    a_out_refresh: assert property (scan_tick |=> o_out == $past(out_ctrl_r))
        else $error("outputs not refreshed on scan tick");
    a_out_hold: assert property (!$past(scan_tick) |-> $stable(o_out))
        else $error("outputs changed between scan ticks");

    for (genvar g = 0; g < NCH; g++) begin : g_chk
        a_status_tick: assert property ($changed(status_r[g]) |-> $past(scan_tick))
            else $error("status changed off the scan tick");
        a_rise_delay: assert property ($rose(status_r[g]) |-> $past(acc_r[g]) >= 22'($past(act_dly_r[g])))
            else $error("status rose before activation delay");
        a_fall_delay: assert property ($fell(status_r[g]) |->
            $past(acc_r[g]) >= 22'($past(drop_dly_r[g])) + ($past(ac_r[g]) ? 22'(dic_pkg::AC_DROP_MS) : 22'h000000))
            else $error("status fell before drop-off delay");
        a_count_rise: assert property ($rose(status_r[g]) && !$past(clr_cmd[g]) |->
            count_r[g] == $past(count_r[g]) + 32'h00000001)
            else $error("counter missed a rising status");
        a_count_clear: assert property (clr_cmd[g] |=> count_r[g] <= 32'h00000001)
            else $error("counter not cleared");
        a_energize: assert property (scan_tick && volt_r[g] > thr_mv(act_thr_r[g]) |=> energ_r[g])
            else $error("input not energized above threshold");
        a_release_lvl: assert property (scan_tick && volt_r[g] < rel_mv[g]
            && volt_r[g] <= thr_mv(act_thr_r[g]) |=> !energ_r[g])
            else $error("input not released below threshold");
        a_status_seq: assert property (s_tick_then_status(g) |=> $stable(status_r[g]) [*2])
            else $error("status toggled twice within a scan");
    end

endmodule // dic_input_conditioner
`default_nettype wire

// file: testbench/dic_field_model.sv
// field wiring model: the voltage seen at each input channel
`timescale 1ns/100ps
`default_nettype none
module dic_field_model (
    input  wire logic                                i_clk,
    output logic [dic_pkg::NCH*dic_pkg::VOLT_W-1:0]  o_volt_mv
);
    logic [dic_pkg::VOLT_W-1:0] mv_r [dic_pkg::NCH];
    initial for (int i = 0; i < dic_pkg::NCH; i++) mv_r[i] = 19'h00000;
    always_comb for (int i = 0; i < dic_pkg::NCH; i++) o_volt_mv[i*dic_pkg::VOLT_W +: dic_pkg::VOLT_W] = mv_r[i];
    // change one channel right after an edge, limited to the card range
    task automatic set_mv(input int ch, input logic [dic_pkg::VOLT_W-1:0] v);
        @(posedge i_clk);
        mv_r[ch] <= (v > 19'h43238) ? 19'h43238 : v;
    endtask
endmodule // dic_field_model
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench for the digital input conditioner
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int SC = 20;
    logic                                         i_clk = 1'b0;
    logic                                         i_rst;
    logic                                         psel;
    logic                                         penable;
    logic                                         pwrite;
    logic [11:0]                                  paddr;
    logic [31:0]                                  pwdata;
    logic [31:0]                                  prdata;
    logic                                         pready;
    logic                                         pslverr;
    logic [7:0]                                   status;
    logic [4:0]                                   out;
    logic                                         irq;
    logic [dic_pkg::NCH*dic_pkg::VOLT_W-1:0]      volt;
    logic [31:0]                                  rq;
    logic                                         err;
    int                                           miscompares = 0;
    int                                           total_checks = 0;
    // ------------------------------------------------------------
    // design and field model
    // ------------------------------------------------------------
    always #5 i_clk = ~i_clk;
    dic_field_model dic_field_model_i (.i_clk(i_clk), .o_volt_mv(volt));
    dic_input_conditioner #(.SCAN_CYCLES(SC)) dic_input_conditioner_i (
        .i_clk(i_clk), .i_rst(i_rst), .i_volt_mv(volt), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_status(status), .o_out(out), .o_irq(irq));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    function automatic logic [11:0] ca(input int ch, input logic [11:0] off);
        return 12'(ch) * dic_pkg::CH_STRIDE + off;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        // pready is looked at as sampled at the rising edge, data taken there too
        do begin
            @(posedge i_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) miscompares++;
        rq = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        chk(rq, e);
    endtask
    task automatic st_chk(input int ch, input logic e);
        apb(1'b0, dic_pkg::OFF_STATUS, 32'h00000000);
        chk({31'h0, rq[ch]}, {31'h0, e});
        chk({31'h0, status[ch]}, {31'h0, e});
    endtask
    task automatic ticks(input int n);
        repeat (n * SC) @(posedge i_clk);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge i_clk);
        miscompares++;
        results();
    end
    initial begin
        i_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        rd_chk(ca(0, dic_pkg::OFF_CFG), 32'h00000000);
        rd_chk(ca(5, dic_pkg::OFF_ACT_THR), 32'h00000370);
        rd_chk(ca(7, dic_pkg::OFF_REL_THR), 32'h00000258);
        rd_chk(ca(0, dic_pkg::OFF_DROP_DLY), 32'h00000000);
        rd_chk(ca(0, dic_pkg::OFF_COUNT), 32'h00000000);
        apb(1'b0, 12'h120, 32'h00000000);
        chk({31'h0, err}, 32'h00000001);
        wr(ca(6, dic_pkg::OFF_ACT_THR), 32'h00000005);
        rd_chk(ca(6, dic_pkg::OFF_ACT_THR), 32'h000000A0);
        dic_field_model_i.set_mv(0, 19'h157C0);
        ticks(2);
        st_chk(0, 1'b0);
        dic_field_model_i.set_mv(0, 19'h15824);
        ticks(2);
        st_chk(0, 1'b1);
        dic_field_model_i.set_mv(0, 19'h0EA60);
        ticks(2);
        st_chk(0, 1'b1);
        dic_field_model_i.set_mv(0, 19'h0EA5F);
        ticks(2);
        st_chk(0, 1'b0);
        rd_chk(ca(0, dic_pkg::OFF_COUNT), 32'h00000001);
        wr(ca(0, dic_pkg::OFF_CNT_CLR), 32'h00000001);
        rd_chk(ca(0, dic_pkg::OFF_COUNT), 32'h00000000);
        rd_chk(ca(0, dic_pkg::OFF_CNT_CLR), 32'h00000000);
        wr(ca(2, dic_pkg::OFF_CFG), 32'h00000001);
        ticks(2);
        st_chk(2, 1'b1);
        dic_field_model_i.set_mv(1, 19'h1E240);
        ticks(1);
        rd_chk(ca(1, dic_pkg::OFF_VOLT), 32'h0001E240);
        wr(ca(3, dic_pkg::OFF_ACT_DLY), 32'h00000014);
        wr(ca(3, dic_pkg::OFF_DROP_DLY), 32'h0000000A);
        dic_field_model_i.set_mv(3, 19'h15BA8);
        ticks(2);
        dic_field_model_i.set_mv(3, 19'h00000);
        ticks(6);
        st_chk(3, 1'b0);
        dic_field_model_i.set_mv(3, 19'h15BA8);
        ticks(3);
        st_chk(3, 1'b0);
        ticks(4);
        st_chk(3, 1'b1);
        dic_field_model_i.set_mv(3, 19'h00000);
        ticks(1);
        st_chk(3, 1'b1);
        ticks(3);
        st_chk(3, 1'b0);
        wr(ca(4, dic_pkg::OFF_CFG), 32'h00000002);
        dic_field_model_i.set_mv(4, 19'h15BA8);
        ticks(2);
        dic_field_model_i.set_mv(4, 19'h04E20);
        ticks(12);
        st_chk(4, 1'b1);
        dic_field_model_i.set_mv(4, 19'h00000);
        ticks(4);
        st_chk(4, 1'b1);
        ticks(5);
        st_chk(4, 1'b0);
        wr(dic_pkg::OFF_IRQ_CLR, 32'h000000FF);
        wr(dic_pkg::OFF_IRQ_EN, 32'h00000001);
        rd_chk(dic_pkg::OFF_IRQ_STAT, 32'h00000000);
        dic_field_model_i.set_mv(0, 19'h15BA8);
        ticks(2);
        @(negedge i_clk);
        chk({31'h0, irq}, 32'h00000001);
        wr(dic_pkg::OFF_IRQ_EN, 32'h00000000);
        repeat (2) @(negedge i_clk);
        chk({31'h0, irq}, 32'h00000000);
        rd_chk(dic_pkg::OFF_IRQ_STAT, 32'h00000001);
        wr(dic_pkg::OFF_OUT_CTRL, 32'h00000015);
        ticks(2);
        @(negedge i_clk);
        chk({27'h0, out}, 32'h00000015);
        results();
    end
endmodule // tb
`default_nettype wire
